/* pkg/sdf_pkg.sv */
// constants and types for the sigma-delta data filter
package sdf_pkg;

   // accumulator width: 3 * log2(256) + 1 sign bit
   localparam int SDF_ACC_W = 25;
   localparam int SDF_OUT_W = 32;
   localparam int SDF_OSR_W = 8;

   // 16-bit mode keeps the top 16 accumulator bits
   localparam int SDF_SHIFT16 = 9;

   // one modulator bit mapped to +1 or -1
   localparam logic [SDF_ACC_W-1:0] SDF_STEP_POS = 25'h0000001;
   localparam logic [SDF_ACC_W-1:0] SDF_STEP_NEG = 25'h1ffffff;
   localparam logic [SDF_ACC_W-1:0] SDF_ACC_RST = 25'h0000000;
   localparam logic [SDF_OSR_W-1:0] SDF_CNT_RST = 8'h00;
   localparam logic [SDF_OUT_W-1:0] SDF_DATA_RST = 32'h00000000;

   // full-scale output limits per mode
   localparam logic [SDF_OUT_W-1:0] SDF_MAX32 = 32'h00ffffff;
   localparam logic [SDF_OUT_W-1:0] SDF_MIN32 = 32'hff000000;
   localparam logic [SDF_OUT_W-1:0] SDF_MAX16 = 32'h00007fff;
   localparam logic [SDF_OUT_W-1:0] SDF_MIN16 = 32'hffff8000;

   // raw word that a full-scale all-ones run yields at ratio 256
   localparam logic [SDF_ACC_W-1:0] SDF_FS_WORD = 25'h1000000;
   localparam logic [SDF_OSR_W-1:0] SDF_OSR256 = 8'hff;

   // software-side timing, kept for the bench
   localparam int SDF_CLK_NS = 100;
   localparam int SDF_HANDLER_NS = 1200;
   localparam int SDF_HANDLER_CYC =
      (SDF_HANDLER_NS + SDF_CLK_NS - 1) / SDF_CLK_NS;
   localparam int SDF_LAT_PAD_MODCLK = 5;

   typedef struct packed {
      logic en;
      logic mode16;
      logic [SDF_OSR_W-1:0] osr_m1;
   } sdf_cfg_s;

   typedef enum logic [1:0] {
      SDF_OFF,
      SDF_FIRST,
      SDF_SETTLE,
      SDF_RUN
   } sdf_state_e;

endpackage : sdf_pkg

/* hdl/sdf_data_filter.sv */
// sinc3 data filter path of the sigma-delta filter module
// Summary of operation
// - all-ones at ratio 256 wraps to minimum
// - output range per 32-bit or 16-bit mode
// - one spurious ack after first enable
// - later acks follow filter configuration exactly
// - reset pulse may give one spurious ack
// - acks correct until the next reset pulse
`timescale 1ns/1ps
`default_nettype none

module sdf_data_filter (
   // clock and reset
   input wire logic mclk_i,
   input wire logic rst_n_i,
   // modulator link, asynchronous to mclk_i
   input wire logic modulator_clock_i,
   input wire logic mod_data_i,
   // configuration and control
   input wire sdf_pkg::sdf_cfg_s cfg_i,
   input wire logic filter_reset_pulse_i,
   input wire logic flag_clr_i,
   // results
   output logic [sdf_pkg::SDF_OUT_W-1:0] data_o,
   output logic data_ack_event_o,
   output logic filter_interrupt_flags_o
);

   localparam int AW = sdf_pkg::SDF_ACC_W;

   function automatic logic [sdf_pkg::SDF_OUT_W-1:0] sdf_fmt(
      input logic [AW-1:0] w,
      input logic m16
   );
      if (m16) begin
         sdf_fmt = {{16{w[AW-1]}}, w[AW-1:sdf_pkg::SDF_SHIFT16]};
      end else begin
         sdf_fmt = {{7{w[AW-1]}}, w};
      end
   endfunction : sdf_fmt

   // link synchronisers
   logic [2:0] clk_s_q;
   logic [2:0] clk_s_d;
   logic [1:0] dat_s_q;
   logic [1:0] dat_s_d;
   logic mod_edge;

   always_comb begin
      clk_s_d = {clk_s_q[1:0], modulator_clock_i};
      dat_s_d = {dat_s_q[0], mod_data_i};
      // only the second and third stages feed the edge finder
      mod_edge = clk_s_q[1] & ~clk_s_q[2];
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         clk_s_q <= 3'h0;
         dat_s_q <= 2'h0;
      end else begin
         clk_s_q <= clk_s_d;
         dat_s_q <= dat_s_d;
      end
   end

   // filter datapath and event state
   logic [AW-1:0] integ_q [3];
   logic [AW-1:0] integ_d [3];
   logic [AW-1:0] cd_q [3];
   logic [AW-1:0] cd_d [3];
   logic [sdf_pkg::SDF_OSR_W-1:0] cnt_q;
   logic [sdf_pkg::SDF_OSR_W-1:0] cnt_d;
   logic [AW-1:0] word_q;
   logic [AW-1:0] word_d;
   logic [sdf_pkg::SDF_OUT_W-1:0] data_q;
   logic [sdf_pkg::SDF_OUT_W-1:0] data_d;
   logic ack_q;
   logic ack_d;
   logic flag_q;
   logic flag_d;
   sdf_pkg::sdf_state_e st_q;
   sdf_pkg::sdf_state_e st_d;
   logic [AW-1:0] c;
   logic [AW-1:0] nxt;
   logic dec;
   logic clear;

   always_comb begin
      integ_d = integ_q;
      cd_d = cd_q;
      cnt_d = cnt_q;
      word_d = word_q;
      data_d = data_q;
      ack_d = 1'b0;
      st_d = st_q;
      flag_d = flag_q;
      c = sdf_pkg::SDF_ACC_RST;
      nxt = sdf_pkg::SDF_ACC_RST;
      dec = 1'b0;
      clear = !cfg_i.en || filter_reset_pulse_i;
      if (clear) begin
         for (int i = 0; i < 3; i++) begin
            integ_d[i] = sdf_pkg::SDF_ACC_RST;
            cd_d[i] = sdf_pkg::SDF_ACC_RST;
         end
         cnt_d = sdf_pkg::SDF_CNT_RST;
         st_d = cfg_i.en ? sdf_pkg::SDF_FIRST : sdf_pkg::SDF_OFF;
      end else if (mod_edge) begin
         integ_d[0] = integ_q[0] + (dat_s_q[1] ? sdf_pkg::SDF_STEP_POS
                                               : sdf_pkg::SDF_STEP_NEG);
         integ_d[1] = integ_q[1] + integ_d[0];
         integ_d[2] = integ_q[2] + integ_d[1];
         if (cnt_q == cfg_i.osr_m1) begin
            dec = 1'b1;
            cnt_d = sdf_pkg::SDF_CNT_RST;
            // modular combs, no saturation at full scale
            c = integ_d[2];
            for (int i = 0; i < 3; i++) begin
               nxt = c - cd_q[i];
               cd_d[i] = c;
               c = nxt;
            end
            word_d = c;
            data_d = sdf_fmt(c, cfg_i.mode16);
            case (st_q)
               // first word is not settled yet
               sdf_pkg::SDF_OFF, sdf_pkg::SDF_FIRST: begin
                  ack_d = 1'b1;
                  st_d = sdf_pkg::SDF_SETTLE;
               end
               sdf_pkg::SDF_SETTLE: begin
                  st_d = sdf_pkg::SDF_RUN;
               end
               sdf_pkg::SDF_RUN: begin
                  ack_d = 1'b1;
               end
               default: begin
                  st_d = sdf_pkg::SDF_OFF;
               end
            endcase
         end else begin
            cnt_d = cnt_q + 8'h01;
         end
      end
      if (flag_clr_i) begin
         flag_d = 1'b0;
      end
      if (ack_d) begin
         flag_d = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < 3; i++) begin
            integ_q[i] <= sdf_pkg::SDF_ACC_RST;
            cd_q[i] <= sdf_pkg::SDF_ACC_RST;
         end
         cnt_q <= sdf_pkg::SDF_CNT_RST;
         word_q <= sdf_pkg::SDF_ACC_RST;
         data_q <= sdf_pkg::SDF_DATA_RST;
         ack_q <= 1'b0;
         flag_q <= 1'b0;
         st_q <= sdf_pkg::SDF_OFF;
      end else begin
         integ_q <= integ_d;
         cd_q <= cd_d;
         cnt_q <= cnt_d;
         word_q <= word_d;
         data_q <= data_d;
         ack_q <= ack_d;
         flag_q <= flag_d;
         st_q <= st_d;
      end
   end

   assign data_o = data_q;
   assign data_ack_event_o = ack_q;
   assign filter_interrupt_flags_o = flag_q;

   default clocking cb @(posedge mclk_i);
   endclocking
   default disable iff (!rst_n_i);

   wrap_full_a: assert property (
      dec && cfg_i.osr_m1 == sdf_pkg::SDF_OSR256 && !cfg_i.mode16
      && c == sdf_pkg::SDF_FS_WORD |=> data_q == sdf_pkg::SDF_MIN32)
      else $error("full-scale word did not wrap to minimum");

   range_32_a: assert property (
      ack_q && !cfg_i.mode16 |-> $signed(data_q) <= $signed(
      sdf_pkg::SDF_MAX32) && $signed(data_q) >= $signed(sdf_pkg::SDF_MIN32))
      else $error("32-bit output out of range");

   range_16_a: assert property (
      dec && cfg_i.mode16 |=> data_q == sdf_fmt(word_q, 1'b1)
      && $signed(data_q) >= $signed(sdf_pkg::SDF_MIN16)
      && $signed(data_q) <= $signed(sdf_pkg::SDF_MAX16))
      else $error("16-bit output wrong");

   first_spur_a: assert property (
      dec && !clear && st_q == sdf_pkg::SDF_FIRST
      |=> ack_q && st_q == sdf_pkg::SDF_SETTLE)
      else $error("first word gave no single ack");

   settle_quiet_a: assert property (
      dec && !clear && st_q == sdf_pkg::SDF_SETTLE
      |=> !ack_q && st_q == sdf_pkg::SDF_RUN)
      else $error("ack during settling");

   resync_start_a: assert property (
      filter_reset_pulse_i && cfg_i.en
      |=> st_q == sdf_pkg::SDF_FIRST && cnt_q == sdf_pkg::SDF_CNT_RST)
      else $error("reset pulse did not restart filter");

   run_ack_a: assert property (
      !dec ##1 (st_q == sdf_pkg::SDF_RUN && !ack_q) [*2] |-> !$past(dec))
      else $error("ack pattern broken in run");

   flag_set_a: assert property (
      ack_q |-> flag_q && (dec || $past(dec)) ##1 !ack_q)
      else $error("ack without flag or back to back");

endmodule : sdf_data_filter

`default_nettype wire

/* tb/sdf_mod_model.sv */
// behavioural sigma-delta modulator driving the filter link
`timescale 1ns/1ps
`default_nettype none

module sdf_mod_model (
   // run request and bit level
   input wire logic run_i,
   input wire logic bit_i,
   // modulator link
   output logic modulator_clock_o,
   output logic mod_data_o
);
   logic live = 1'b0;

   initial begin
      modulator_clock_o = 1'b0;
      mod_data_o = 1'b0;
      // odd offset keeps the link unrelated to mclk
      #37;
      forever begin
         #400;
         if (!run_i) begin
            // clock stands still, data no longer trustworthy
            modulator_clock_o = 1'b0;
            mod_data_o = ~mod_data_o;
         end else if (live) begin
            modulator_clock_o = ~modulator_clock_o;
            if (!modulator_clock_o) mod_data_o = bit_i;
         end else mod_data_o = bit_i;
         live = run_i;
      end
   end
endmodule : sdf_mod_model

`default_nettype wire

/* tb/tb.sv */
// self-checking bench for the sigma-delta data filter
`timescale 1ns/1ps
`default_nettype none

module tb;
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic run = 1'b0;
   logic bit_v = 1'b0;
   logic fres = 1'b0;
   logic clr = 1'b0;
   logic mod_clk, mod_dat, ack, flag;
   logic [31:0] data;
   sdf_pkg::sdf_cfg_s cfg = '0;
   int fail_count = 0;
   int n_compared = 0;
   int acks = 0;

   always #50 mclk = ~mclk;
   // counted mid-cycle, away from the edge that launches the pulse
   always @(negedge mclk) if (ack === 1'b1) acks++;

   sdf_data_filter uut (.mclk_i(mclk), .rst_n_i(rst_n),
      .modulator_clock_i(mod_clk), .mod_data_i(mod_dat),
      .cfg_i(cfg), .filter_reset_pulse_i(fres), .flag_clr_i(clr),
      .data_o(data), .data_ack_event_o(ack),
      .filter_interrupt_flags_o(flag));

   sdf_mod_model modm (.run_i(run), .bit_i(bit_v),
      .modulator_clock_o(mod_clk), .mod_data_o(mod_dat));

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic conclude();
      $display("compared %0d, mismatched %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude

   // r modulator edges, then the running ack total
   task automatic word(input int r, input int exp_acks);
      repeat (r) @(posedge mod_clk);
      repeat (6) @(negedge mclk);
      check(32'(acks), 32'(exp_acks));
   endtask : word

   // disable long enough to count as a fresh first enable
   task automatic start(input logic m16, input logic [7:0] om1,
                        input logic b);
      @(negedge mclk);
      run = 1'b0;
      cfg.en = 1'b0;
      repeat (20) @(negedge mclk);
      cfg = '{en: 1'b1, mode16: m16, osr_m1: om1};
      bit_v = b;
      acks = 0;
      run = 1'b1;
   endtask : start

   task automatic t_first_ack();
      start(1'b0, 8'h03, 1'b0);
      word(4, 1);
      word(4, 1);
      word(4, 2);
      word(4, 3);
      check(data, 32'hffffffc0);
      check(32'(flag), 32'h1);
      clr = 1'b1;
      @(negedge mclk);
      clr = 1'b0;
      check(32'(flag), 32'h0);
      fres = 1'b1;
      @(negedge mclk);
      fres = 1'b0;
      acks = 0;
      word(4, 1);
      word(4, 1);
      word(4, 2);
      word(4, 3);
      check(data, 32'hffffffc0);
      check(32'(flag), 32'h1);
   endtask : t_first_ack

   task automatic pulse_clr();
      clr = 1'b1;
      @(negedge mclk);
      clr = 1'b0;
   endtask : pulse_clr

   // software sequences: late event enable, handler after a pulse
   task automatic t_sw_seq();
      start(1'b0, 8'h03, 1'b0);
      // three words of latency plus five link clocks
      word(12 + sdf_pkg::SDF_LAT_PAD_MODCLK, 3);
      pulse_clr();
      check(32'(flag), 32'h0);
      word(3, 4);
      check(32'(flag), 32'h1);
      check(data, 32'hffffffc0);
      fres = 1'b1;
      @(negedge mclk);
      fres = 1'b0;
      acks = 0;
      // handler no sooner than 1.2 us after the pulse
      repeat (sdf_pkg::SDF_HANDLER_CYC) @(negedge mclk);
      pulse_clr();
      check(32'(flag), 32'h0);
      // two link edges went by while the handler waited
      word(2, 1);
      // the first sample's flag is cleared, the settling second sample raises none
      pulse_clr();
      check(32'(flag), 32'h0);
      word(4, 1);
      check(32'(flag), 32'h0);
      word(4, 2);
      // beyond two samples the flag is left set
      check(32'(flag), 32'h1);
      check(data, 32'hffffffc0);
   endtask : t_sw_seq

   // four words at ratio 256 so the combs have settled
   task automatic t_wrap(input logic m16, input logic [31:0] exp);
      start(m16, 8'hff, 1'b1);
      word(512, 1);
      word(512, 3);
      check(data, exp);
   endtask : t_wrap

   initial begin
      repeat (3) @(negedge mclk);
      rst_n = 1'b1;
      t_first_ack();
      t_sw_seq();
      t_wrap(1'b0, sdf_pkg::SDF_MIN32);
      t_wrap(1'b1, sdf_pkg::SDF_MIN16);
      conclude();
   end

   // about twice the expected run length
   initial begin
      #3000000;
      fail_count++;
      conclude();
   end
endmodule : tb

`default_nettype wire
